// >>> include/hub_status_pkg.sv
// Package for the sensor-hub write byte and status block.
// Assumes an APB slave with 32-bit data and byte addresses four times the index.
package hub_status_pkg;

    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0]  IDX_HUB_WRITE_BYTE    = 8'h21;
    localparam logic [7:0]  IDX_HUB_MASTER_STATUS = 8'h22;
    localparam logic [7:0]  IDX_IRQ_STATUS        = 8'h30;
    localparam logic [7:0]  IDX_IRQ_MASK          = 8'h31;
    localparam logic [7:0]  IDX_HUB_CONTROL       = 8'h32;
    localparam logic [11:0] ADDR_HUB_WRITE_BYTE    = {2'b00, IDX_HUB_WRITE_BYTE, 2'b00};
    localparam logic [11:0] ADDR_HUB_MASTER_STATUS = {2'b00, IDX_HUB_MASTER_STATUS, 2'b00};
    localparam logic [11:0] ADDR_IRQ_STATUS        = {2'b00, IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] ADDR_IRQ_MASK          = {2'b00, IDX_IRQ_MASK, 2'b00};
    localparam logic [11:0] ADDR_HUB_CONTROL       = {2'b00, IDX_HUB_CONTROL, 2'b00};

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RST_WRITE_BYTE = 8'h00;
    localparam logic [7:0] RST_STATUS     = 8'h00;
    localparam logic [4:0] RST_IRQ        = 5'h00;
    localparam int         BIT_CONCLUDED  = 0;
    localparam int         BIT_NOACK0     = 3;
    localparam int         BIT_DONE       = 7;
    localparam int         CTL_ONE_SHOT   = 0;

    // Events reported by the hub engine, one cycle pulses
    typedef struct packed {
        logic       write_done;
        logic [3:0] noack;
        logic       seq_start;
        logic       seq_end;
    } hub_event_s;

endpackage

// >>> hdl/hub_write_status.sv
// Sensor-hub write byte, status register and interrupt logic on APB.
// Assumes the hub engine on the same clock drives one-cycle event pulses.
// Overview of operation
// RULE1: Eight-bit write byte, reset zero, sent out
// RULE2: One-shot enabled write completion sets done flag
// RULE3: Fourth target noack sets its flag
// RULE4: Third target noack sets its flag
// RULE5: Second target noack sets its flag
// RULE6: First target noack sets its flag
// RULE7: Concluded flag low during, high after sequence
// RULE8: Unused bits zero, status writes ignored
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module hub_write_status
    import hub_status_pkg::*;
(
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    input  wire logic [3:0]  I_PSTRB,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    input  wire hub_event_s  I_HUB_EVENT,
    output logic      [7:0]  O_FIRST_TARGET_WRITE_BYTE,
    output logic             O_ONE_SHOT_WRITE_ENABLE,
    output logic             O_IRQ
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic access;
    logic wr_en;
    logic rd_en;
    logic rd_load;
    logic mapped;
    logic ack_r;
    logic ack_nxt;

    // One wait state: the first access cycle loads the read word into a
    // flip-flop, the second answers. Costs a cycle per transfer but keeps
    // read data off a combinational path to the bus.
    assign access    = I_PSEL & I_PENABLE;
    assign wr_en     = access & I_PWRITE & ack_r;
    assign rd_en     = access & ~I_PWRITE & ack_r;
    assign rd_load   = access & ~I_PWRITE & ~ack_r;
    assign O_PREADY  = access & ack_r;
    assign O_PSLVERR = access & ack_r & ~mapped;

    // Answer flag: high for exactly the second cycle of each access phase
    always_comb begin
        ack_nxt = access & ~ack_r;
    end

    // Handshake state; cleared by reset so no transfer starts answered
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= ack_nxt;
        end
    end

    function automatic logic hit(input logic [11:0] addr, input logic [11:0] target);
        hit = (addr == target);
    endfunction

    assign mapped = hit(I_PADDR, ADDR_HUB_WRITE_BYTE) | hit(I_PADDR, ADDR_HUB_MASTER_STATUS)
                  | hit(I_PADDR, ADDR_IRQ_STATUS) | hit(I_PADDR, ADDR_IRQ_MASK)
                  | hit(I_PADDR, ADDR_HUB_CONTROL);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0]  write_byte_r, write_byte_nxt;
    logic        one_shot_r, one_shot_nxt;
    logic        done_r, done_nxt;
    logic [3:0]  noack_r, noack_nxt;
    logic        concluded_r, concluded_nxt;
    logic [4:0]  irq_stat_r, irq_stat_nxt;
    logic [4:0]  irq_mask_r, irq_mask_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [7:0]  status_view;
    logic [4:0]  irq_events;
    logic        wr_stb0;

    // Byte lane 0 carries all eight-bit data; upper lanes are ignored
    assign wr_stb0 = wr_en & I_PSTRB[0];

    // Status layout, the two unused bits tied low
    assign status_view = {done_r, noack_r, 2'b00, concluded_r}; // RULE8

    // Interrupt sources: done, four noacks share layout order
    assign irq_events = {I_HUB_EVENT.write_done & one_shot_r, I_HUB_EVENT.noack};

    // ------------------------------------------------------------
    // Software-written registers
    // ------------------------------------------------------------
    // Only an answered write with lane 0 strobed changes a register
    always_comb begin
        write_byte_nxt = write_byte_r;
        one_shot_nxt   = one_shot_r;
        irq_mask_nxt   = irq_mask_r;
        if (wr_stb0 && hit(I_PADDR, ADDR_HUB_WRITE_BYTE)) begin
            write_byte_nxt = I_PWDATA[7:0]; // RULE1
        end
        if (wr_stb0 && hit(I_PADDR, ADDR_HUB_CONTROL)) begin
            one_shot_nxt = I_PWDATA[CTL_ONE_SHOT];
        end
        if (wr_stb0 && hit(I_PADDR, ADDR_IRQ_MASK)) begin
            irq_mask_nxt = I_PWDATA[4:0];
        end
    end

    // Registering only; synchronous reset to constants
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            write_byte_r <= RST_WRITE_BYTE; // RULE1
            one_shot_r   <= 1'b0;
            irq_mask_r   <= RST_IRQ;
        end else begin
            write_byte_r <= write_byte_nxt;
            one_shot_r   <= one_shot_nxt;
            irq_mask_r   <= irq_mask_nxt;
        end
    end

    // ------------------------------------------------------------
    // Hub status flags
    // ------------------------------------------------------------
    // Host writes to the status address never reach these flags; a new
    // sequence clears them, and an event in the same cycle still wins
    always_comb begin
        done_nxt      = done_r;
        noack_nxt     = noack_r;
        concluded_nxt = concluded_r;
        if (I_HUB_EVENT.seq_start) begin
            concluded_nxt = 1'b0; // RULE7
            done_nxt      = 1'b0;
            noack_nxt     = 4'h0;
        end
        if (I_HUB_EVENT.seq_end) begin
            concluded_nxt = 1'b1; // RULE7
        end
        if (I_HUB_EVENT.write_done && one_shot_r) begin
            done_nxt = 1'b1; // RULE2
        end
        noack_nxt[3] = noack_nxt[3] | I_HUB_EVENT.noack[3]; // RULE3
        noack_nxt[2] = noack_nxt[2] | I_HUB_EVENT.noack[2]; // RULE4
        noack_nxt[1] = noack_nxt[1] | I_HUB_EVENT.noack[1]; // RULE5
        noack_nxt[0] = noack_nxt[0] | I_HUB_EVENT.noack[0]; // RULE6
    end

    // Reset values come from the status layout constants
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            done_r      <= RST_STATUS[BIT_DONE];
            noack_r     <= RST_STATUS[BIT_NOACK0 +: 4];
            concluded_r <= RST_STATUS[BIT_CONCLUDED];
        end else begin
            done_r      <= done_nxt;
            noack_r     <= noack_nxt;
            concluded_r <= concluded_nxt;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    // Write one to clear; a coincident event keeps its bit set, so an
    // event that lands during a clear is never lost
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (wr_stb0 && hit(I_PADDR, ADDR_IRQ_STATUS)) begin
            irq_stat_nxt = irq_stat_r & ~I_PWDATA[4:0];
        end
        irq_stat_nxt = irq_stat_nxt | irq_events;
    end

    // Registering only
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            irq_stat_r <= RST_IRQ;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Loaded in the first access cycle, shown in the answer cycle, then
    // dropped back to zero so the bus never sees a stale word
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        if (rd_load) begin
            if (hit(I_PADDR, ADDR_HUB_WRITE_BYTE)) begin
                prdata_nxt = {24'h00_0000, write_byte_r};
            end else if (hit(I_PADDR, ADDR_HUB_MASTER_STATUS)) begin
                prdata_nxt = {24'h00_0000, status_view}; // RULE8
            end else if (hit(I_PADDR, ADDR_IRQ_STATUS)) begin
                prdata_nxt = {27'h000_0000, irq_stat_r};
            end else if (hit(I_PADDR, ADDR_IRQ_MASK)) begin
                prdata_nxt = {27'h000_0000, irq_mask_r};
            end else if (hit(I_PADDR, ADDR_HUB_CONTROL)) begin
                prdata_nxt = {31'h0000_0000, one_shot_r};
            end else begin
                prdata_nxt = 32'h0000_0000;
            end
        end
    end

    // Registering only
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            prdata_r <= 32'h0000_0000;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Read word straight from its flip-flop; zero outside the answer cycle
    assign O_PRDATA = prdata_r;

    assign O_FIRST_TARGET_WRITE_BYTE = write_byte_r; // RULE1
    assign O_ONE_SHOT_WRITE_ENABLE   = one_shot_r;
    assign O_IRQ                     = |(irq_stat_r & irq_mask_r);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_write_byte_load: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // RULE1
        (wr_stb0 && I_PADDR == ADDR_HUB_WRITE_BYTE) |=> O_FIRST_TARGET_WRITE_BYTE == $past(I_PWDATA[7:0]))
        else $error("write byte not loaded");
    a_done_set: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // RULE2
        (I_HUB_EVENT.write_done && one_shot_r) |=> done_r)
        else $error("done flag not set");
    a_done_needs_mode: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // RULE2
        (!done_r && !(I_HUB_EVENT.write_done && one_shot_r)) |=> !done_r)
        else $error("done flag set without one-shot write");
    a_noack3_set: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // RULE3
        I_HUB_EVENT.noack[3] |=> noack_r[3] && irq_stat_r[3])
        else $error("fourth noack lost");
    a_noack2_set: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // RULE4
        I_HUB_EVENT.noack[2] |=> noack_r[2])
        else $error("third noack lost");
    a_noack1_set: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // RULE5
        I_HUB_EVENT.noack[1] |=> noack_r[1])
        else $error("second noack lost");
    a_noack0_set: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // RULE6
        I_HUB_EVENT.noack[0] |=> noack_r[0])
        else $error("first noack lost");
    a_seq_conclude: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // RULE7
        (I_HUB_EVENT.seq_start && !I_HUB_EVENT.seq_end) |=> !concluded_r)
        else $error("concluded flag wrong at sequence start");
    a_seq_end_set: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // RULE7
        I_HUB_EVENT.seq_end |=> concluded_r)
        else $error("concluded flag not set");
    a_status_ro: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // RULE8
        (rd_en && I_PADDR == ADDR_HUB_MASTER_STATUS) |-> O_PRDATA[2:1] == 2'b00
        && O_PRDATA[31:8] == 24'h00_0000)
        else $error("unused status bits not zero");
    // Write byte changes only on an answered write to its address
    a_write_byte_hold: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // RULE1
        !(wr_stb0 && I_PADDR == ADDR_HUB_WRITE_BYTE) |=> $stable(write_byte_r))
        else $error("write byte changed without a write");
    // Done flag stays until the next sequence starts
    a_done_sticky: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // RULE2
        (done_r && !I_HUB_EVENT.seq_start) |=> done_r)
        else $error("done flag dropped inside a sequence");
    // Noack flags only rise between sequence starts
    a_noack_sticky: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // RULE3 RULE4 RULE5 RULE6
        !I_HUB_EVENT.seq_start |=> (noack_r & $past(noack_r)) == $past(noack_r))
        else $error("noack flag dropped inside a sequence");
    // Concluded flag holds its level between start and end pulses
    a_concluded_hold: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // RULE7
        (!I_HUB_EVENT.seq_start && !I_HUB_EVENT.seq_end) |=> $stable(concluded_r))
        else $error("concluded flag moved without a pulse");
    // Host writes to the status address leave every flag alone
    a_status_wr_ignored: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // RULE8
        (wr_en && I_PADDR == ADDR_HUB_MASTER_STATUS && I_HUB_EVENT == '0)
        |=> $stable(status_view))
        else $error("status write changed a flag");

    // ------------------------------------------------------------
    // Bus and interrupt assertions
    // ------------------------------------------------------------
    // Handshake: first access cycle waits, second answers
    a_ready_waits: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        (I_PSEL && !I_PENABLE) ##1 (I_PSEL && I_PENABLE) |-> !O_PREADY ##1 O_PREADY)
        else $error("access phase not answered after one wait cycle");
    // Read word shows only in the answer cycle of a read
    a_read_idle_zero: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        !rd_en |-> O_PRDATA == 32'h0000_0000)
        else $error("read data outside a read answer");
    // Unmapped reads answer zero with an error
    a_unmapped_read: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        (rd_en && !mapped) |-> O_PSLVERR && O_PRDATA == 32'h0000_0000)
        else $error("unmapped read not refused");
    // A hub event beats a write-one clear of the same bit
    a_irq_set_wins: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        (|irq_events) |=> (irq_stat_r & $past(irq_events)) == $past(irq_events))
        else $error("interrupt event lost");

endmodule

// >>> testbench/hub_engine_model.sv
// Behavioural hub engine: turns a start request into one sensor-hub sequence.
// Assumes the bench pulses go for one cycle while busy is low, on the core clock.
`timescale 1ns/1ps
module hub_engine_model
    import hub_status_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [3:0] nack,
    input  wire logic       wr_en,
    output hub_event_s      ev,
    output logic            busy
);
    logic [3:0] cnt;
    initial begin
        ev = '0;
        busy = 1'b0;
        cnt = 4'h0;
    end
    // ----------------------------------------------------------------
    // Sequence: start, long gap, outcome pulses, end
    // ----------------------------------------------------------------
    // Long gap lets the bench read status mid-sequence
    always @(posedge clk) begin
        ev <= '0;
        if (go && !busy) begin
            busy <= 1'b1;
            cnt <= 4'h0;
            ev.seq_start <= 1'b1;
        end else if (busy) begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'h6) begin
                ev.noack <= nack;
                ev.write_done <= wr_en;
            end
            if (cnt == 4'h7) begin
                ev.seq_end <= 1'b1;
                busy <= 1'b0;
            end
        end
    end
endmodule

// >>> testbench/hub_write_status_tb.sv
// Self-checking bench for the hub write byte, status and interrupt block.
// Assumes an APB slave that may add wait states, hub engine model on the same clock.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module hub_write_status_tb;
    import hub_status_pkg::*;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, go = 0, wr = 0;
    logic        pready, pslverr, err, oneshot, irq, busy, os, w;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q, d;
    logic [3:0]  nack = 0;
    logic [7:0]  owb;
    logic [4:0]  msk, ex;
    hub_event_s  ev;
    int          n_fail = 0, total_checks = 0, seed = 32'ha7ac6064, n;

    hub_write_status dut (.I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'hF),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_HUB_EVENT(ev),
        .O_FIRST_TARGET_WRITE_BYTE(owb), .O_ONE_SHOT_WRITE_ENABLE(oneshot), .O_IRQ(irq));
    hub_engine_model partner (.clk(clk), .go(go), .nack(nack), .wr_en(wr), .ev(ev),
        .busy(busy));

    initial forever #5 clk = ~clk;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Expected status byte after a concluded sequence
    function automatic logic [31:0] exp_status(logic o, logic v, logic [3:0] k);
        return {24'h0, o & v, k, 2'b00, 1'b1};
    endfunction

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wv, input logic [11:0] a, input logic [31:0] dv);
        int c;
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= wv; paddr <= a; pwdata <= dv;
        @(posedge clk);
        pen <= 1;
        c = 0;
        do begin @(posedge clk); c++; end while (pready !== 1'b1 && c < 64);
        if (c >= 64) n_fail++;
        q = prdata;
        err = pslverr;
        psel <= 0; pen <= 0;
    endtask

    task automatic print_verdict;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        #500000;
        n_fail++;
        print_verdict;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst <= 0;
        apb(0, ADDR_HUB_WRITE_BYTE, 0); `CHK("wbyte reset", 32'h0, q)
        apb(0, ADDR_HUB_MASTER_STATUS, 0); `CHK("status reset", 32'h0, q)
        `CHK("mapped err", 1'b0, err)
        apb(0, 12'h100, 0); `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, q)
        for (int i = 0; i < 12; i++) begin
            d = $random(seed); os = $random(seed); w = $random(seed);
            nack = $random(seed); msk = $random(seed);
            if (i == 0) begin os = 1; w = 1; nack = 4'hF; msk = 5'h1F; end // all flags at once
            apb(1, ADDR_HUB_WRITE_BYTE, d);
            apb(0, ADDR_HUB_WRITE_BYTE, 0); `CHK("wbyte read", {24'h0, d[7:0]}, q)
            `CHK("wbyte port", d[7:0], owb)
            apb(1, ADDR_HUB_CONTROL, {31'h0, os});
            @(negedge clk); // Output settles after the answering edge
            `CHK("one shot", os, oneshot)
            apb(1, ADDR_IRQ_MASK, {27'h0, msk});
            wr <= w;
            @(posedge clk) go <= 1;
            @(posedge clk) go <= 0;
            apb(0, ADDR_HUB_MASTER_STATUS, 0); `CHK("status busy", 32'h0, q)
            n = 0;
            while (busy && n < 100) begin @(posedge clk); n++; end
            @(posedge clk);
            apb(0, ADDR_HUB_MASTER_STATUS, 0);
            `CHK("status end", exp_status(os, w, nack), q)
            apb(1, ADDR_HUB_MASTER_STATUS, $random(seed));
            apb(0, ADDR_HUB_MASTER_STATUS, 0);
            `CHK("status wr", exp_status(os, w, nack), q)
            ex = {os & w, nack};
            `CHK("irq level", |(ex & msk), irq)
            apb(0, ADDR_IRQ_STATUS, 0); `CHK("irq status", {27'h0, ex}, q)
            apb(1, ADDR_IRQ_STATUS, 32'h1F);
            @(negedge clk); // Clear lands at the answering edge
            `CHK("irq clear", 1'b0, irq)
        end
        print_verdict;
    end
endmodule
